// file: logic/scm_defs.svh
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH
// Register offsets in units of 32-bit words, decoded from address bits [5:2].
`define SCM_OFS_CTRL    4'h0
`define SCM_OFS_STAT    4'h1
`define SCM_OFS_COUNT   4'h2
`define SCM_OFS_TXDATA  4'h3
`define SCM_OFS_RXDATA  4'h4
`define SCM_OFS_SRST    4'h7
// Control register field positions.
`define SCM_CTL_TRIG    0
`define SCM_CTL_EN      1
`define SCM_CTL_LOOP    2
`define SCM_CTL_TEST    3
`define SCM_CTL_MODE    4
`define SCM_CTL_CS      5
`define SCM_CTL_RATE    6
// Status register field positions.
`define SCM_ST_RXFULL   5
`define SCM_ST_DONE     6
`define SCM_ST_TXEMPTY  7
// Reset values.
`define SCM_CTRL_RST    7'h20
`define SCM_SRST_RST    1'h1
// Master clock of the block, in kHz, and the FIFO shape.
`define SCM_PCLK_KHZ    3686.4
`define SCM_FIFO_DEPTH  8
`define SCM_BYTE_W      8
`define SCM_COUNT_W     11
`endif

// file: logic/scm_pkg.sv
package scm_pkg;
   typedef enum logic [1:0] {
      SCM_IDLE  = 2'b00,
      SCM_LOW   = 2'b01,
      SCM_HIGH  = 2'b11,
      SCM_PAUSE = 2'b10
   } scm_state_e;
   typedef logic [7:0] scm_byte_t;
endpackage

// file: logic/scm_fifo_if.sv
`timescale 1ns/1ps
interface scm_fifo_if #(parameter int W = 8);
   logic         push;
   logic [W-1:0] wdata;
   logic         pop;
   logic [W-1:0] rdata;
   logic         full;
   logic         empty;
   logic         clear;
   modport owner (input push, wdata, pop, clear, output rdata, full, empty);
   modport user  (output push, wdata, pop, clear, input rdata, full, empty);
endinterface

// file: logic/scm_fifo.sv
`timescale 1ns/1ps
`include "scm_defs.svh"
module scm_fifo import scm_pkg::*; #(
   parameter int W     = `SCM_BYTE_W,
   parameter int DEPTH = `SCM_FIFO_DEPTH
) (
   input  wire logic i_clock,  // Master clock.
   input  wire logic i_rst,    // Asynchronous reset, active high.
   scm_fifo_if.owner f         // Queue port.
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0]   cnt_reg, cnt_next;
   logic          do_push, do_pop;

   assign do_push = f.push && !f.full;
   assign do_pop  = f.pop && !f.empty;
   assign f.full  = (cnt_reg == (AW+1)'(DEPTH));
   assign f.empty = (cnt_reg == '0);
   assign f.rdata = mem_reg[rp_reg];

   always_comb begin
      wp_next  = wp_reg;
      rp_next  = rp_reg;
      cnt_next = cnt_reg;
      if (f.clear) begin
         wp_next  = '0;
         rp_next  = '0;
         cnt_next = '0;
      end else begin
         if (do_push) wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
         if (do_pop)  rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
         cnt_next = cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage carries no reset; only the pointers define its contents.
   always_ff @(posedge i_clock) begin
      if (do_push && !f.clear) mem_reg[wp_reg] <= f.wdata;
   end
endmodule

// file: logic/scm_clkdiv.sv
`timescale 1ns/1ps
module scm_clkdiv #(
   parameter int DIV_W = 4
) (
   input  wire logic             i_clock,  // Master clock.
   input  wire logic             i_rst,    // Asynchronous reset, active high.
   input  wire logic             i_run,    // Count while high, restart while low.
   input  wire logic [DIV_W-1:0] i_div,    // Half-period in master cycles minus one.
   output logic                  o_tick    // One-cycle pulse per serial half-period.
);
   logic [DIV_W-1:0] cnt_reg, cnt_next;

   always_comb begin
      cnt_next = cnt_reg;
      o_tick   = 1'b0;
      if (!i_run) begin
         cnt_next = '0;
      end else if (cnt_reg >= i_div) begin
         cnt_next = '0;
         o_tick   = 1'b1;
      end else begin
         cnt_next = cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) cnt_reg <= '0;
      else       cnt_reg <= cnt_next;
   end
endmodule

// file: logic/scm_master.sv
// How it works
// - Block alone drives select, serial clock and MOSI, and samples MISO.
// - Engine moves whole 8-bit bytes only.
// - Transfers start only while chip select is low; a byte in progress finishes even if select rises.
// - No CRC logic; CRC bytes are ordinary data.
// - Transmit and receive queues hold eight 8-bit entries each.
// - Queued bytes load in order into the shift register, sent serially.
// - Interrupt once the transmit queue is empty and its last byte has shifted out.
// - MISO bits shift in; in receive mode each full byte is pushed into receive queue.
// - Full receive queue sets receive-full flag and raises interrupt.
// - Full receive queue halts serial clock until the queue is drained and trigger is set again.
// - Interrupt high only when enabled and a transfer completed, the transmit queue drained, or the receive queue is full.
// - Everything is timed from the 3.6864 MHz master clock.
// - With select high, decode address bits 5:2; write line high means write.
// - Data bus driven only during reads.
// - Writing zero to soft reset clears internal counters and the receive queue, but not the transmit queue.
// - Exactly the programmed count of bytes is exchanged.
// - Trigger bit starts serial clocks; host clears it after completion.
// - Receive mode clocks in the count, then sets done and interrupts.
`timescale 1ns/1ps
`include "scm_defs.svh"
module scm_master import scm_pkg::*; #(
   parameter int COUNT_W = `SCM_COUNT_W,
   parameter int DIV_W   = 4
) (
   input  wire logic        i_clock,                 // 3.6864 MHz master clock.
   input  wire logic        i_rst,                   // Asynchronous reset, high.
   input  wire logic        i_peripheral_select_in,  // Block selected.
   input  wire logic        i_peripheral_strobe,     // Access strobe.
   input  wire logic        i_peripheral_write,      // High write, low read.
   input  wire logic [3:0]  i_peripheral_addr_bits,  // Register index.
   input  wire logic [15:0] i_peripheral_data_bus,   // Write data.
   output logic      [15:0] o_peripheral_data_bus,   // Read data.
   output logic             o_peripheral_data_oe,    // High while driving read data.
   output logic             o_chip_select_n,         // Card select, low active.
   output logic             o_serial_clock_out,      // Serial clock to card.
   output logic             o_mosi,                  // Serial data to card.
   input  wire logic        i_miso,                  // Serial data from card.
   output logic             o_serial_irq_out         // Interrupt to host.
);
   ////////////////////////////////////////////////////////////////////////////////////
   logic [6:0]          ctrl_reg, ctrl_next;
   logic [COUNT_W-1:0]  count_reg, count_next;
   logic [COUNT_W-1:0]  done_cnt_reg, done_cnt_next;
   logic                srst_reg, srst_next;
   logic                done_reg, done_next;
   logic                txdrain_reg, txdrain_next;
   logic                rxfull_reg, rxfull_next;
   logic                pause_reg, pause_next;
   logic                stb_d_reg;
   scm_state_e          st_reg, st_next;
   scm_byte_t           sh_reg, sh_next;
   logic [2:0]          bit_reg, bit_next;
   logic                mosi_reg, mosi_next;
   logic                sclk_reg, sclk_next;
   logic [15:0]         rd_reg, rd_next;
   logic                acc, wr_acc, rd_acc, tick, clr, loaded;
   logic                trig_rise, trig_d_reg, rx_in, mode_rx, run;
   logic [DIV_W-1:0]    div;

   scm_fifo_if #(.W(`SCM_BYTE_W)) txq ();
   scm_fifo_if #(.W(`SCM_BYTE_W)) rxq ();

   scm_fifo #(.W(`SCM_BYTE_W), .DEPTH(`SCM_FIFO_DEPTH)) u_txq (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .f       (txq)
   );
   scm_fifo #(.W(`SCM_BYTE_W), .DEPTH(`SCM_FIFO_DEPTH)) u_rxq (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .f       (rxq)
   );

   // Rate bit: bypass runs the serial clock at half the master clock, the
   // divide setting halves it again, both derived from the master clock.
   assign div = ctrl_reg[`SCM_CTL_RATE] ? DIV_W'(1) : DIV_W'(0);
   assign run = (st_reg == SCM_LOW) || (st_reg == SCM_HIGH);

   scm_clkdiv #(.DIV_W(DIV_W)) u_div (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_run   (run),
      .i_div   (div),
      .o_tick  (tick)
   );

   ////////////////////////////////////////////////////////////////////////////////////
   // One access per strobe rising edge, so a long strobe cannot pop twice.
   assign acc     = i_peripheral_select_in && i_peripheral_strobe && !stb_d_reg;
   assign wr_acc  = acc && i_peripheral_write;
   assign rd_acc  = acc && !i_peripheral_write;
   assign clr     = !srst_reg;
   assign mode_rx = ctrl_reg[`SCM_CTL_MODE];
   assign rx_in   = ctrl_reg[`SCM_CTL_LOOP] ? mosi_reg : i_miso;
   assign trig_rise = ctrl_reg[`SCM_CTL_TRIG] && !trig_d_reg;

   assign txq.push  = wr_acc && (i_peripheral_addr_bits == `SCM_OFS_TXDATA);
   assign txq.wdata = i_peripheral_data_bus[7:0];
   assign txq.clear = 1'b0;
   assign rxq.pop   = rd_acc && (i_peripheral_addr_bits == `SCM_OFS_RXDATA);
   assign rxq.clear = clr;

   always_comb begin
      ctrl_next  = ctrl_reg;
      count_next = count_reg;
      srst_next  = srst_reg;
      rd_next    = rd_reg;
      if (wr_acc) begin
         case (i_peripheral_addr_bits)
            `SCM_OFS_CTRL:  ctrl_next  = i_peripheral_data_bus[6:0];
            `SCM_OFS_COUNT: count_next = i_peripheral_data_bus[COUNT_W-1:0];
            `SCM_OFS_SRST:  srst_next  = i_peripheral_data_bus[0];
            default:        ;
         endcase
      end
      if (rd_acc) begin
         case (i_peripheral_addr_bits)
            `SCM_OFS_CTRL:   rd_next = {9'h000, ctrl_reg};
            `SCM_OFS_STAT:   rd_next = {8'h00, txdrain_reg, done_reg, rxfull_reg, 5'h00};
            `SCM_OFS_COUNT:  rd_next = 16'(count_reg);
            `SCM_OFS_RXDATA: rd_next = {8'h00, rxq.rdata};
            `SCM_OFS_SRST:   rd_next = {15'h0000, srst_reg};
            default:         rd_next = 16'h0000;
         endcase
      end
   end

   assign o_peripheral_data_bus = rd_reg;
   assign o_peripheral_data_oe  = i_peripheral_select_in && !i_peripheral_write;

   ////////////////////////////////////////////////////////////////////////////////////
   // Serial engine. A byte slot starts low; MOSI is set at the start of the low
   // phase, MISO is sampled at the rising edge, and the falling edge ends a bit.
   assign loaded = (st_reg == SCM_IDLE) && ctrl_reg[`SCM_CTL_EN] && !o_chip_select_n;

   always_comb begin
      st_next      = st_reg;
      sh_next      = sh_reg;
      bit_next     = bit_reg;
      mosi_next    = mosi_reg;
      sclk_next    = sclk_reg;
      done_cnt_next = done_cnt_reg;
      done_next    = done_reg;
      txdrain_next = txdrain_reg;
      rxfull_next  = rxfull_reg;
      pause_next   = pause_reg;
      txq.pop      = 1'b0;
      rxq.push     = 1'b0;
      rxq.wdata    = {sh_reg[6:0], rx_in};
      // Clearing the trigger acknowledges the completion flags.
      if (!ctrl_reg[`SCM_CTL_TRIG]) begin
         done_next    = 1'b0;
         txdrain_next = 1'b0;
      end
      rxfull_next = rxq.full;
      case (st_reg)
         SCM_IDLE: begin
            sclk_next = 1'b0;
            if (loaded && ctrl_reg[`SCM_CTL_TRIG] && !done_reg && !pause_reg
                && done_cnt_reg != count_reg) begin
               // A full queue with bytes still owed stops the clock here, so no
               // further byte can overwrite an entry the host has not read yet.
               if (mode_rx && rxq.full) begin
                  pause_next = 1'b1;
                  st_next    = SCM_PAUSE;
               end else if (!mode_rx && !txq.empty) begin
                  sh_next   = txq.rdata;
                  mosi_next = txq.rdata[7];
                  txq.pop   = 1'b1;
                  bit_next  = 3'h0;
                  st_next   = SCM_LOW;
               end else if (mode_rx && !rxq.full) begin
                  sh_next   = 8'hff;
                  mosi_next = 1'b1;
                  bit_next  = 3'h0;
                  st_next   = SCM_LOW;
               end
            end
         end
         SCM_LOW: begin
            if (tick) begin
               sclk_next = 1'b1;
               sh_next   = {sh_reg[6:0], rx_in};
               st_next   = SCM_HIGH;
            end
         end
         SCM_HIGH: begin
            if (tick) begin
               sclk_next = 1'b0;
               mosi_next = sh_reg[7];
               if (bit_reg == 3'h7) begin
                  st_next       = SCM_IDLE;
                  done_cnt_next = done_cnt_reg + 1'b1;
                  if (mode_rx) begin
                     rxq.push  = 1'b1;
                     rxq.wdata = sh_reg;
                     if (done_cnt_reg + 1'b1 == count_reg) done_next = 1'b1;
                  end else begin
                     if (txq.empty) txdrain_next = 1'b1;
                     if (done_cnt_reg + 1'b1 == count_reg) done_next = 1'b1;
                  end
               end else begin
                  bit_next = bit_reg + 1'b1;
                  st_next  = SCM_LOW;
               end
            end
         end
         SCM_PAUSE: begin
            // Resume only on a fresh trigger after the host drained the queue.
            if (trig_rise && rxq.empty) begin
               pause_next = 1'b0;
               st_next    = SCM_IDLE;
            end
         end
         default: st_next = SCM_IDLE;
      endcase
      if (clr) begin
         done_cnt_next = '0;
         done_next     = 1'b0;
         txdrain_next  = 1'b0;
         rxfull_next   = 1'b0;
         pause_next    = 1'b0;
         st_next       = SCM_IDLE;
         sclk_next     = 1'b0;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg     <= `SCM_CTRL_RST;
         count_reg    <= '0;
         srst_reg     <= `SCM_SRST_RST;
         rd_reg       <= 16'h0000;
         stb_d_reg    <= 1'b0;
         trig_d_reg   <= 1'b0;
         st_reg       <= SCM_IDLE;
         sh_reg       <= 8'h00;
         bit_reg      <= 3'h0;
         mosi_reg     <= 1'b1;
         sclk_reg     <= 1'b0;
         done_cnt_reg <= '0;
         done_reg     <= 1'b0;
         txdrain_reg  <= 1'b0;
         rxfull_reg   <= 1'b0;
         pause_reg    <= 1'b0;
      end else begin
         ctrl_reg     <= ctrl_next;
         count_reg    <= count_next;
         srst_reg     <= srst_next;
         rd_reg       <= rd_next;
         stb_d_reg    <= i_peripheral_select_in && i_peripheral_strobe;
         trig_d_reg   <= ctrl_reg[`SCM_CTL_TRIG];
         st_reg       <= st_next;
         sh_reg       <= sh_next;
         bit_reg      <= bit_next;
         mosi_reg     <= mosi_next;
         sclk_reg     <= sclk_next;
         done_cnt_reg <= done_cnt_next;
         done_reg     <= done_next;
         txdrain_reg  <= txdrain_next;
         rxfull_reg   <= rxfull_next;
         pause_reg    <= pause_next;
      end
   end

   // The host owns chip select; the engine never moves it.
   assign o_chip_select_n    = ctrl_reg[`SCM_CTL_CS];
   assign o_serial_clock_out = sclk_reg;
   assign o_mosi             = mosi_reg;
   // Enable bit gates the interrupt; no CRC logic exists anywhere here.
   assign o_serial_irq_out = ctrl_reg[`SCM_CTL_EN]
                             && (done_reg || txdrain_reg || rxfull_reg);
endmodule

// file: verification/scm_master_monitor.sv
`timescale 1ns/1ps
`include "scm_defs.svh"
module scm_master_monitor import scm_pkg::*; #(
   parameter int COUNT_W = `SCM_COUNT_W,
   parameter int DIV_W   = 4
) (
   input wire logic        i_clock,                 // Master clock.
   input wire logic        i_rst,                   // Asynchronous reset, high.
   input wire logic        i_peripheral_select_in,  // Block selected.
   input wire logic        i_peripheral_strobe,     // Access strobe.
   input wire logic        i_peripheral_write,      // High write.
   input wire logic [3:0]  i_peripheral_addr_bits,  // Register index.
   input wire logic [15:0] i_peripheral_data_bus,   // Write data.
   input wire logic [15:0] o_peripheral_data_bus,   // Read data.
   input wire logic        o_peripheral_data_oe,    // Read data enable.
   input wire logic        o_chip_select_n,         // Card select.
   input wire logic        o_serial_clock_out,      // Serial clock.
   input wire logic        o_mosi,                  // Serial data out.
   input wire logic        i_miso,                  // Serial data in.
   input wire logic        o_serial_irq_out         // Interrupt.
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////////
   logic               acc_prev_reg;
   logic [6:0]         ctrl_reg;
   logic [COUNT_W-1:0] count_reg;
   logic [15:0]        rises_reg;
   logic               take;
   logic               wr_take;
   assign take    = i_peripheral_select_in & i_peripheral_strobe & ~acc_prev_reg;
   assign wr_take = take & i_peripheral_write;
   // Shadows of the host's writes, so outputs can be tied to what was asked.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         acc_prev_reg <= 1'b0;
         ctrl_reg     <= `SCM_CTRL_RST;
         count_reg    <= '0;
         rises_reg    <= 16'h0;
      end else begin
         acc_prev_reg <= i_peripheral_select_in & i_peripheral_strobe;
         if (wr_take && i_peripheral_addr_bits == `SCM_OFS_CTRL) begin
            ctrl_reg <= i_peripheral_data_bus[6:0];
         end
         if (wr_take && i_peripheral_addr_bits == `SCM_OFS_COUNT) begin
            count_reg <= i_peripheral_data_bus[COUNT_W-1:0];
         end
         if (wr_take && i_peripheral_addr_bits == `SCM_OFS_SRST && !i_peripheral_data_bus[0]) begin
            rises_reg <= 16'h0;
         end else if ($rose(o_serial_clock_out)) begin
            rises_reg <= rises_reg + 16'h1;
         end
      end
   end
   sequence s_rise;
      $rose(o_serial_clock_out);
   endsequence
   sequence s_slow_high;
      o_serial_clock_out ##1 !o_serial_clock_out;
   endsequence
   property p_oe;
      o_peripheral_data_oe == (i_peripheral_select_in & ~i_peripheral_write);
   endproperty
   a_oe: assert property (p_oe) else $error("data bus enable wrong");
   property p_cs;
      o_chip_select_n == ctrl_reg[`SCM_CTL_CS];
   endproperty
   a_cs: assert property (p_cs) else $error("chip select not as written");
   property p_gate;
      o_serial_clock_out |-> ctrl_reg[`SCM_CTL_TRIG] && !o_chip_select_n;
   endproperty
   a_gate: assert property (p_gate) else $error("serial clock without trigger");
   property p_mosi;
      $changed(o_mosi) |-> !o_serial_clock_out;
   endproperty
   a_mosi: assert property (p_mosi) else $error("data changed while clock high");
   property p_fast;
      s_rise and !ctrl_reg[`SCM_CTL_RATE] |=> !o_serial_clock_out;
   endproperty
   a_fast: assert property (p_fast) else $error("fast high half wrong");
   property p_slow;
      s_rise and ctrl_reg[`SCM_CTL_RATE] |=> s_slow_high;
   endproperty
   a_slow: assert property (p_slow) else $error("slow high half wrong");
   property p_byte;
      $rose(o_serial_irq_out) |-> rises_reg[2:0] == 3'h0;
   endproperty
   a_byte: assert property (p_byte) else $error("interrupt inside a byte");
   property p_cap;
      int'(rises_reg) <= 8 * int'(count_reg);
   endproperty
   a_cap: assert property (p_cap) else $error("more bits than counted");
   property p_irq;
      o_serial_irq_out |-> ctrl_reg[`SCM_CTL_EN];
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt while disabled");
endmodule
bind scm_master scm_master_monitor #(.COUNT_W(COUNT_W), .DIV_W(DIV_W)) scm_master_monitor_inst (
   .i_clock(i_clock), .i_rst(i_rst), .i_peripheral_select_in(i_peripheral_select_in),
   .i_peripheral_strobe(i_peripheral_strobe), .i_peripheral_write(i_peripheral_write),
   .i_peripheral_addr_bits(i_peripheral_addr_bits), .i_peripheral_data_bus(i_peripheral_data_bus),
   .o_peripheral_data_bus(o_peripheral_data_bus), .o_peripheral_data_oe(o_peripheral_data_oe),
   .o_chip_select_n(o_chip_select_n), .o_serial_clock_out(o_serial_clock_out), .o_mosi(o_mosi),
   .i_miso(i_miso), .o_serial_irq_out(o_serial_irq_out));

// file: verification/scm_card_model.sv
`timescale 1ns/1ps
module scm_card_model (
   input  wire logic i_cs_n,  // Card select, low active.
   input  wire logic i_sclk,  // Serial clock from the master.
   input  wire logic i_mosi,  // Data from the master.
   output logic      o_miso   // Data to the master.
);
   logic [7:0] tx_sh;
   logic [7:0] rx_sh;
   logic [7:0] rx_log [0:15];
   int         nb;
   int         idx;
   int         rx_cnt;
   logic       fresh;
   function automatic logic [7:0] card_byte(input int k);
      return 8'(8'h5a + k * 29);
   endfunction
   initial o_miso = 1'b1;
   ////////////////////////////////////////////////////////////////////////
   always @(negedge i_cs_n) begin
      nb = 0;
      idx = 0;
      rx_cnt = 0;
      fresh = 1'b0;
      tx_sh = card_byte(0);
      o_miso = tx_sh[7];
   end
   // A released line must not keep its last bit, or a late sample would pass.
   always @(posedge i_cs_n) o_miso = ~o_miso;
   always @(posedge i_sclk) if (!i_cs_n) begin
      rx_sh = {rx_sh[6:0], i_mosi};
      nb++;
      if (nb == 8) begin
         rx_log[rx_cnt % 16] = rx_sh;
         rx_cnt++;
         nb = 0;
         idx++;
         tx_sh = card_byte(idx);
         fresh = 1'b1;
      end
   end
   always @(negedge i_sclk) if (!i_cs_n) begin
      if (fresh) fresh = 1'b0;
      else tx_sh = tx_sh << 1;
      o_miso = tx_sh[7];
   end
endmodule

// file: verification/scm_master_tb_top.sv
`timescale 1ns/1ps
`include "scm_defs.svh"
module scm_master_tb_top;
   typedef struct {int n; int pushes; logic rate; logic mode;
                   logic [15:0] st; logic [15:0] m;} scm_row_s;
   logic        clk;
   logic        rst;
   logic        sel;
   logic        stb;
   logic        wr;
   logic [3:0]  adr;
   logic [15:0] wd;
   logic [15:0] q;
   logic        seen;
   wire  [15:0] rd_bus;
   wire         cs_n, sclk, mosi, miso, irq;
   int          failures, tests_run, cyc;
   scm_row_s    rows [5] = '{'{6, 6, 0, 0, 16'hc0, 16'hc0}, '{1, 1, 1, 0, 16'hc0, 16'hc0},
      '{8, 9, 0, 0, 16'hc0, 16'hc0}, '{1, 0, 1, 1, 16'h40, 16'h60}, '{4, 0, 0, 1, 16'h40, 16'h60}};
   scm_master scm_master_inst (.i_clock(clk), .i_rst(rst), .i_peripheral_select_in(sel),
      .i_peripheral_strobe(stb), .i_peripheral_write(wr), .i_peripheral_addr_bits(adr),
      .i_peripheral_data_bus(wd), .o_peripheral_data_bus(rd_bus), .o_peripheral_data_oe(),
      .o_chip_select_n(cs_n), .o_serial_clock_out(sclk), .o_mosi(mosi), .i_miso(miso),
      .o_serial_irq_out(irq));
   scm_card_model scm_card_model_inst (.i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi), .o_miso(miso));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] ctl(logic rate, logic cs, logic mode, logic en, logic trig);
      return {9'h0, rate, cs, mode, 2'b00, en, trig};
   endfunction
   function automatic logic [15:0] tx_byte(int k);
      return {8'h00, 8'(8'hc3 ^ (k * 37))};
   endfunction
   function automatic logic [15:0] card_byte(int k);
      return {8'h00, 8'(8'h5a + k * 29)};
   endfunction
   task automatic tally_and_finish();
      if (failures == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Strobe drops for a cycle after each access; back-to-back strobes are not taken.
   task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
      sel <= 1'b1; stb <= 1'b1; wr <= w; adr <= a; wd <= d;
      @(posedge clk); #1;
      sel <= 1'b0; stb <= 1'b0;
      @(posedge clk); #1;
      q = rd_bus;
   endtask
   task automatic poll_done();
      for (int i = 0; i < 400; i++) begin
         acc(1'b0, `SCM_OFS_STAT, 16'h0);
         if (q[`SCM_ST_DONE] === 1'b1) break;
      end
   endtask
   task automatic start(int n, int pushes, logic rate, logic mode);
      acc(1'b1, `SCM_OFS_SRST, 16'h0);
      acc(1'b1, `SCM_OFS_SRST, 16'h1);
      acc(1'b1, `SCM_OFS_COUNT, 16'(n));
      acc(1'b1, `SCM_OFS_CTRL, ctl(rate, 1'b0, mode, 1'b1, 1'b0));
      for (int k = 0; k < pushes; k++) acc(1'b1, `SCM_OFS_TXDATA, tx_byte(k));
      acc(1'b1, `SCM_OFS_CTRL, ctl(rate, 1'b0, mode, 1'b1, 1'b1));
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      rst = 1'b1; sel = 1'b0; stb = 1'b0; wr = 1'b0; adr = 4'h0; wd = 16'h0;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      foreach (rows[r]) begin
         start(rows[r].n, rows[r].pushes, rows[r].rate, rows[r].mode);
         poll_done();
         chk(q & rows[r].m, rows[r].st);
         chk({15'h0, irq}, 16'h1);
         if (rows[r].mode) begin
            for (int k = 0; k < rows[r].n; k++) begin
               acc(1'b0, `SCM_OFS_RXDATA, 16'h0);
               chk(q & 16'hff, card_byte(k));
            end
         end else begin
            chk(16'(scm_card_model_inst.rx_cnt), 16'(rows[r].n));
            for (int k = 0; k < rows[r].n; k++)
               chk({8'h00, scm_card_model_inst.rx_log[k]}, tx_byte(k));
         end
         acc(1'b1, `SCM_OFS_CTRL, ctl(rows[r].rate, 1'b0, rows[r].mode, 1'b0, 1'b1));
         chk({15'h0, irq}, 16'h0);
         acc(1'b1, `SCM_OFS_CTRL, ctl(rows[r].rate, 1'b1, rows[r].mode, 1'b1, 1'b0));
         chk({15'h0, irq}, 16'h0);
      end
      // Ten bytes into an eight-deep queue: the clock must stall until drained.
      start(10, 0, 1'b0, 1'b1);
      for (int i = 0; i < 2000 && irq !== 1'b1; i++) begin
         @(posedge clk); #1;
      end
      acc(1'b0, `SCM_OFS_STAT, 16'h0);
      chk(q & 16'h60, 16'h20);
      seen = 1'b0;
      repeat (20) begin
         @(posedge clk); #1;
         if (sclk !== 1'b0) seen = 1'b1;
      end
      #1 chk({15'h0, seen}, 16'h0);
      for (int k = 0; k < 8; k++) begin
         acc(1'b0, `SCM_OFS_RXDATA, 16'h0);
         chk(q & 16'hff, card_byte(k));
      end
      acc(1'b1, `SCM_OFS_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
      acc(1'b1, `SCM_OFS_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
      poll_done();
      chk(q & 16'h40, 16'h40);
      for (int k = 8; k < 10; k++) begin
         acc(1'b0, `SCM_OFS_RXDATA, 16'h0);
         chk(q & 16'hff, card_byte(k));
      end
      acc(1'b1, `SCM_OFS_CTRL, ctl(1'b0, 1'b1, 1'b1, 1'b1, 1'b0));
      acc(1'b0, 4'h5, 16'h0);
      chk(q, 16'h0);
      // A reset in mid-frame must at once put select and MOSI high and clock and interrupt low.
      start(6, 6, 1'b1, 1'b0);
      repeat (10) @(posedge clk);
      #1 rst = 1'b1;
      @(posedge clk); #1;
      chk({12'h0, cs_n, sclk, mosi, irq}, 16'ha);
      rst = 1'b0;
      @(posedge clk); #1;
      acc(1'b0, `SCM_OFS_CTRL, 16'h0);
      chk(q & 16'h7f, 16'h20);
      acc(1'b0, `SCM_OFS_STAT, 16'h0);
      chk(q & 16'he0, 16'h0);
      // Loopback in receive mode hears the idle-high MOSI, not the card's byte.
      acc(1'b1, `SCM_OFS_SRST, 16'h0);
      acc(1'b1, `SCM_OFS_SRST, 16'h1);
      acc(1'b1, `SCM_OFS_COUNT, 16'h1);
      acc(1'b1, `SCM_OFS_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b0) | 16'h4);
      acc(1'b1, `SCM_OFS_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b1) | 16'h4);
      poll_done();
      acc(1'b0, `SCM_OFS_RXDATA, 16'h0);
      chk(q & 16'hff, 16'hff);
      tally_and_finish();
   end
endmodule
